/* File: src/orad_pkg.sv */
// Constants for the on-chip RAM access decoder.
// Assumes a 24-bit CPU address, a 16-bit internal data path and a 20 MHz system clock.
package orad_pkg;

   // ----------------------------------------------------------------
   // Register map (word indices on the Avalon slave)
   // ----------------------------------------------------------------
   localparam logic [15:0] SYS_CTRL_IDX = 16'hfff2;
   localparam logic [15:0] STATUS_IDX = 16'hfff3;
   localparam logic [7:0] SYS_CTRL_RST = 8'h0b;
   localparam int RAM_EN_BIT = 0;

   // ----------------------------------------------------------------
   // Status register fields
   // ----------------------------------------------------------------
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_BUSY_BIT = 3;
   localparam int STAT_BLANK_BIT = 4;
   localparam int STAT_EXT_BIT = 5;

   // ----------------------------------------------------------------
   // Address windows
   // ----------------------------------------------------------------
   localparam logic [19:0] SHORT_BASE = 20'hfdf10;
   localparam logic [19:0] SHORT_TOP = 20'hfff0f;
   localparam logic [23:0] LONG_BASE = 24'hffdf10;
   localparam logic [23:0] LONG_TOP = 24'hffff0f;
   localparam logic [12:0] RAM_BASE_LOW = 13'h1f10;

   // ----------------------------------------------------------------
   // Operating modes and fixed values
   // ----------------------------------------------------------------
   localparam logic [2:0] MODE_1 = 3'h1;
   localparam logic [2:0] MODE_6 = 3'h6;
   localparam logic [2:0] MODE_SINGLE = 3'h7;
   localparam logic [15:0] BLANK_WORD = 16'hffff;
   localparam logic [7:0] BLANK_BYTE = 8'hff;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int RAM_STATES = 2;

   typedef enum logic [1:0] {ST_IDLE, ST_RAM, ST_EXT} orad_state_t;

endpackage

/* File: src/orad_ram.sv */
// On-chip 8 kbyte static RAM with its mode-dependent address decode and enable bit.
// Assumes a CPU request held until acknowledged, a system mode input and an Avalon-MM master.
`timescale 1ns/1ps

module orad_ram #(
   parameter int RAM_BYTES = 8192
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [2:0] mode_i,
   input wire logic cpu_req_i,
   input wire logic cpu_we_i,
   input wire logic cpu_word_i,
   input wire logic [23:0] cpu_addr_i,
   input wire logic [15:0] cpu_wdata_i,
   output logic cpu_ack_o,
   output logic [15:0] cpu_rdata_o,
   output logic ext_req_o,
   output logic ext_we_o,
   output logic ext_word_o,
   output logic [23:0] ext_addr_o,
   output logic [15:0] ext_wdata_o,
   input wire logic ext_ack_i,
   input wire logic [15:0] ext_rdata_i,
   input wire logic [15:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o
);

   localparam int WORDS = RAM_BYTES / 2;
   localparam int IDX_W = $clog2(WORDS);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic in_window(input logic [2:0] m, input logic [23:0] a);
      logic r;
      r = 1'b0;
      case (m)
         3'h1, 3'h2, 3'h5, 3'h7: begin
            r = (a[19:0] >= orad_pkg::SHORT_BASE) && (a[19:0] <= orad_pkg::SHORT_TOP);
         end
         3'h3, 3'h4, 3'h6: begin
            r = (a >= orad_pkg::LONG_BASE) && (a <= orad_pkg::LONG_TOP);
         end
         default: begin
            r = 1'b0;
         end
      endcase
      return r;
   endfunction

   function automatic logic [IDX_W-1:0] word_index(input logic [23:0] a);
      logic [12:0] off;
      off = a[12:0] - orad_pkg::RAM_BASE_LOW;
      return off[IDX_W:1];
   endfunction

   // ----------------------------------------------------------------
   // State and storage
   // ----------------------------------------------------------------
   orad_pkg::orad_state_t st_q;
   logic [15:0] mem_q [WORDS];
   logic [7:0] sys_ctrl_q;
   logic [IDX_W-1:0] idx_q;
   logic odd_q;
   logic we_q;
   logic word_q;
   logic [15:0] wdata_q;
   logic blank_q;
   logic last_ext_q;
   logic cpu_ack_q;
   logic [15:0] cpu_rdata_q;
   logic ext_req_q;
   logic ext_we_q;
   logic ext_word_q;
   logic [23:0] ext_addr_q;
   logic [15:0] ext_wdata_q;
   logic avs_wait_q;
   logic [31:0] avs_rdata_q;

   logic ram_en;
   logic take;
   logic hit;
   logic expanded;
   logic bus_req;
   logic bus_go;
   logic to_ram;

   assign ram_en = sys_ctrl_q[orad_pkg::RAM_EN_BIT];
   assign hit = in_window(mode_i, cpu_addr_i);
   assign to_ram = hit && (ram_en || mode_i == orad_pkg::MODE_SINGLE);
   assign expanded = (mode_i >= orad_pkg::MODE_1) && (mode_i <= orad_pkg::MODE_6);
   // A held request is not taken again in the cycle its ack shows
   assign take = cpu_req_i && (st_q == orad_pkg::ST_IDLE) && !cpu_ack_q;
   assign bus_req = avs_read_i || avs_write_i;
   assign bus_go = bus_req && !avs_wait_q;

   // ----------------------------------------------------------------
   // Access sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= orad_pkg::ST_IDLE;
      end else begin
         case (st_q)
            orad_pkg::ST_IDLE: begin
               if (take) begin
                  if (to_ram) begin
                     st_q <= orad_pkg::ST_RAM;
                  end else begin
                     st_q <= orad_pkg::ST_EXT;
                  end
               end
            end
            orad_pkg::ST_RAM: begin
               st_q <= orad_pkg::ST_IDLE;
            end
            orad_pkg::ST_EXT: begin
               if (ext_ack_i) begin
                  st_q <= orad_pkg::ST_IDLE;
               end
            end
            default: begin
               st_q <= orad_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idx_q <= '0;
         odd_q <= 1'b0;
         we_q <= 1'b0;
         word_q <= 1'b0;
         wdata_q <= 16'h0000;
         blank_q <= 1'b0;
         last_ext_q <= 1'b0;
      end else if (take) begin
         idx_q <= word_index(cpu_addr_i);
         odd_q <= cpu_addr_i[0];
         we_q <= cpu_we_i;
         word_q <= cpu_word_i;
         wdata_q <= cpu_wdata_i;
         blank_q <= hit && !ram_en && (mode_i == orad_pkg::MODE_SINGLE);
         last_ext_q <= !to_ram;
      end
   end

   // ----------------------------------------------------------------
   // RAM array
   // ----------------------------------------------------------------
   // No reset on the array: contents are undefined after power-up
   always_ff @(posedge clk_i) begin
      if (st_q == orad_pkg::ST_RAM && we_q && !blank_q) begin
         if (word_q) begin
            mem_q[idx_q] <= wdata_q;
         end else if (odd_q) begin
            mem_q[idx_q][7:0] <= wdata_q[15:8];
         end else begin
            mem_q[idx_q][15:8] <= wdata_q[15:8];
         end
      end
   end

   // ----------------------------------------------------------------
   // CPU answer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cpu_ack_q <= 1'b0;
         cpu_rdata_q <= 16'h0000;
      end else begin
         cpu_ack_q <= (st_q == orad_pkg::ST_RAM) || (st_q == orad_pkg::ST_EXT && ext_ack_i);
         if (st_q == orad_pkg::ST_RAM && !we_q) begin
            if (blank_q) begin
               cpu_rdata_q <= orad_pkg::BLANK_WORD;
            end else if (word_q) begin
               cpu_rdata_q <= mem_q[idx_q];
            end else if (odd_q) begin
               cpu_rdata_q <= {mem_q[idx_q][7:0], orad_pkg::BLANK_BYTE};
            end else begin
               cpu_rdata_q <= {mem_q[idx_q][15:8], orad_pkg::BLANK_BYTE};
            end
         end else if (st_q == orad_pkg::ST_EXT && ext_ack_i && !ext_we_q) begin
            cpu_rdata_q <= ext_rdata_i;
         end
      end
   end

   // ----------------------------------------------------------------
   // External forwarding
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ext_req_q <= 1'b0;
         ext_we_q <= 1'b0;
         ext_word_q <= 1'b0;
         ext_addr_q <= 24'h000000;
         ext_wdata_q <= 16'h0000;
      end else if (take && !to_ram) begin
         ext_req_q <= 1'b1;
         ext_we_q <= cpu_we_i;
         ext_word_q <= cpu_word_i;
         ext_addr_q <= cpu_addr_i;
         ext_wdata_q <= cpu_wdata_i;
      end else if (ext_ack_i) begin
         ext_req_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Avalon-MM register slave
   // ----------------------------------------------------------------
   // One wait cycle per access keeps read data registered
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avs_wait_q <= 1'b1;
         avs_rdata_q <= 32'h00000000;
      end else begin
         avs_wait_q <= !(bus_req && avs_wait_q);
         if (bus_req && avs_wait_q) begin
            case (avs_address_i)
               orad_pkg::SYS_CTRL_IDX: begin
                  avs_rdata_q <= {24'h000000, sys_ctrl_q};
               end
               orad_pkg::STATUS_IDX: begin
                  avs_rdata_q <= 32'h00000000;
                  avs_rdata_q[orad_pkg::STAT_MODE_LSB +: 3] <= mode_i;
                  avs_rdata_q[orad_pkg::STAT_BUSY_BIT] <= (st_q != orad_pkg::ST_IDLE);
                  avs_rdata_q[orad_pkg::STAT_BLANK_BIT] <= blank_q;
                  avs_rdata_q[orad_pkg::STAT_EXT_BIT] <= last_ext_q;
               end
               default: begin
                  avs_rdata_q <= 32'h00000000;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sys_ctrl_q <= orad_pkg::SYS_CTRL_RST;
      end else if (bus_go && avs_write_i && avs_byteenable_i[0]
                   && avs_address_i == orad_pkg::SYS_CTRL_IDX) begin
         sys_ctrl_q <= avs_writedata_i[7:0];
      end
   end

   assign cpu_ack_o = cpu_ack_q;
   assign cpu_rdata_o = cpu_rdata_q;
   assign ext_req_o = ext_req_q;
   assign ext_we_o = ext_we_q;
   assign ext_word_o = ext_word_q;
   assign ext_addr_o = ext_addr_q;
   assign ext_wdata_o = ext_wdata_q;
   assign avs_readdata_o = avs_rdata_q;
   assign avs_waitrequest_o = avs_wait_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_ram_two_states: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      take && hit && ram_en |=> !cpu_ack_o ##1 cpu_ack_o && !ext_req_o)
      else $error("RAM access not answered in two states");

   a_enabled_stays_in: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      take && hit && ram_en |=> !ext_req_o ##1 !ext_req_o)
      else $error("Enabled RAM access leaked outside");

   a_short_window_edge: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      take && ram_en && mode_i == 3'h5 && cpu_addr_i[19:0] == 20'hfff10 |=> ext_req_o)
      else $error("Address past short window not forwarded");

   a_long_window_top: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      take && ram_en && mode_i == 3'h4 && cpu_addr_i == 24'hffff0f |-> ##2 cpu_ack_o && !ext_req_o)
      else $error("Top of long window missed");

   a_disabled_forward: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      take && hit && !ram_en && expanded |=> ext_req_o && ext_addr_o == $past(cpu_addr_i))
      else $error("Disabled window access not forwarded");

   a_blank_read_ff: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      take && hit && !ram_en && mode_i == 3'h7 && !cpu_we_i |-> ##2 cpu_ack_o && cpu_rdata_o == 16'hffff)
      else $error("Single-chip disabled read not H'FF");

   a_byte_upper_lane: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      take && hit && ram_en && cpu_we_i && !cpu_word_i && !cpu_addr_i[0]
      |-> ##2 mem_q[idx_q][15:8] == $past(cpu_wdata_i[15:8], 2))
      else $error("Byte write not taken from upper lane");

   a_word_full_width: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      take && hit && ram_en && cpu_we_i && cpu_word_i |-> ##2 mem_q[idx_q] == $past(cpu_wdata_i, 2))
      else $error("Word write not stored on 16 bits");

   a_enable_write: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      bus_go && avs_write_i && avs_byteenable_i[0] && avs_address_i == orad_pkg::SYS_CTRL_IDX
      |=> ram_en == $past(avs_writedata_i[0]))
      else $error("Enable bit not written");

   a_enable_reload: assert property (
      @(posedge clk_i) $rose(rst_n_i) |-> ram_en && sys_ctrl_q == orad_pkg::SYS_CTRL_RST)
      else $error("Enable bit not reloaded at reset release");

endmodule

/* File: sim/orad_ext_model.sv */
// Responder standing in for the external address space behind the decoder.
// Assumes the decoder holds a forwarded request until it sees one ack pulse.
`timescale 1ns/1ps

module orad_ext_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] delay_i,
   input wire logic ext_req_i,
   input wire logic ext_we_i,
   input wire logic [23:0] ext_addr_i,
   input wire logic [15:0] ext_wdata_i,
   output logic ext_ack_o,
   output logic [15:0] ext_rdata_o,
   output logic [15:0] last_wdata_o
);
   // ----------------------------------------------------------------
   // Responder
   // ----------------------------------------------------------------
   logic [3:0] wait_q;

   // Data lines toggle outside the ack cycle, so a stale capture shows
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_q <= 4'h0;
         ext_ack_o <= 1'b0;
         ext_rdata_o <= 16'h0000;
         last_wdata_o <= 16'h0000;
      end else begin
         ext_ack_o <= 1'b0;
         ext_rdata_o <= ~ext_rdata_o;
         if (ext_req_i && !ext_ack_o) begin
            if (wait_q == delay_i) begin
               wait_q <= 4'h0;
               ext_ack_o <= 1'b1;
               ext_rdata_o <= ext_addr_i[15:0] ^ 16'h5a5a;
               if (ext_we_i) begin
                  last_wdata_o <= ext_wdata_i;
               end
            end else begin
               wait_q <= wait_q + 4'h1;
            end
         end
      end
   end
endmodule

/* File: sim/orad_ram_tb_top.sv */
// Self-checking bench for the on-chip RAM access decoder.
// Assumes the external responder model; CPU and register bus are driven here.
`timescale 1ns/1ps

module orad_ram_tb_top;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [2:0] mode_i = 3'h1;
   logic cpu_req_i = 1'b0;
   logic cpu_we_i = 1'b0;
   logic cpu_word_i = 1'b0;
   logic [23:0] cpu_addr_i = 24'h000000;
   logic [15:0] cpu_wdata_i = 16'h0000;
   logic cpu_ack_o, ext_req_o, ext_we_o, ext_word_o, ext_ack_i, avs_waitrequest_o;
   logic [15:0] cpu_rdata_o, ext_wdata_o, ext_rdata_i, last_wdata, rd;
   logic [23:0] ext_addr_o;
   logic [15:0] avs_address_i = 16'h0000;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h00000000;
   logic [3:0] avs_byteenable_i = 4'h1;
   logic [31:0] avs_readdata_o, rr;
   logic [3:0] delay = 4'h0;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   int n;

   always #25 clk_i = ~clk_i;

   orad_ram dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .mode_i(mode_i), .cpu_req_i(cpu_req_i), .cpu_we_i(cpu_we_i),
      .cpu_word_i(cpu_word_i), .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i), .cpu_ack_o(cpu_ack_o),
      .cpu_rdata_o(cpu_rdata_o), .ext_req_o(ext_req_o), .ext_we_o(ext_we_o), .ext_word_o(ext_word_o),
      .ext_addr_o(ext_addr_o), .ext_wdata_o(ext_wdata_o), .ext_ack_i(ext_ack_i), .ext_rdata_i(ext_rdata_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o));

   orad_ext_model ext (.clk_i(clk_i), .rst_n_i(rst_n_i), .delay_i(delay), .ext_req_i(ext_req_o),
      .ext_we_i(ext_we_o), .ext_addr_i(ext_addr_o), .ext_wdata_i(ext_wdata_o), .ext_ack_o(ext_ack_i),
      .ext_rdata_o(ext_rdata_i), .last_wdata_o(last_wdata));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic stop_test;
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Request held until ack is sampled; n counts edges to the answer
   task automatic cpu(input logic we, input logic word, input logic [23:0] a, input logic [15:0] wd);
      @(posedge clk_i);
      cpu_req_i <= 1'b1;
      cpu_we_i <= we;
      cpu_word_i <= word;
      cpu_addr_i <= a;
      cpu_wdata_i <= wd;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (cpu_ack_o !== 1'b1);
      rd = cpu_rdata_o;
      cpu_req_i <= 1'b0;
   endtask

   task automatic avs(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
      @(posedge clk_i);
      avs_read_i <= !wr;
      avs_write_i <= wr;
      avs_address_i <= idx;
      avs_writedata_i <= {24'h000000, wd};
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      rr = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      avs(1'b0, orad_pkg::SYS_CTRL_IDX, 8'h00);
      chk(rr, 32'h0000000b);
      // Write without the low byte lane must be ignored
      @(posedge clk_i);
      avs_byteenable_i <= 4'h0;
      avs(1'b1, orad_pkg::SYS_CTRL_IDX, 8'h00);
      avs_byteenable_i <= 4'h1;
      avs(1'b0, orad_pkg::SYS_CTRL_IDX, 8'h00);
      chk(rr, 32'h0000000b);
      avs(1'b1, 16'h0010, 8'h5a);
      avs(1'b0, 16'h0010, 8'h00);
      chk(rr, 32'h00000000);
      $display("test regs done");
   endtask

   task automatic t_modes;
      logic long_w;
      logic [23:0] base, top;
      for (int m = 1; m <= 7; m++) begin
         @(posedge clk_i);
         mode_i <= 3'(m);
         long_w = (m == 3 || m == 4 || m == 6);
         base = long_w ? orad_pkg::LONG_BASE : {4'h0, orad_pkg::SHORT_BASE};
         top = long_w ? orad_pkg::LONG_TOP : {4'h0, orad_pkg::SHORT_TOP};
         cpu(1'b1, 1'b1, base, 16'h1230 + 16'(m));
         chk(n, 3);
         cpu(1'b0, 1'b1, base, 16'h0000);
         chk(rd, 16'h1230 + 16'(m));
         cpu(1'b1, 1'b0, base + 24'h000002, {8'ha0 + 8'(m), 8'h00});
         cpu(1'b0, 1'b0, base + 24'h000002, 16'h0000);
         chk(rd, {8'ha0 + 8'(m), 8'hff});
         cpu(1'b1, 1'b0, top, {8'hc0 + 8'(m), 8'h00});
         cpu(1'b0, 1'b0, top, 16'h0000);
         chk(n, 3);
         chk(rd, {8'hc0 + 8'(m), 8'hff});
         cpu(1'b0, 1'b1, base - 24'h000001, 16'h0000);
         chk(rd, (base[15:0] - 16'h0001) ^ 16'h5a5a);
         cpu(1'b0, 1'b1, top + 24'h000001, 16'h0000);
         chk(rd, (top[15:0] + 16'h0001) ^ 16'h5a5a);
      end
      $display("test modes done");
   endtask

   task automatic t_disable;
      avs(1'b1, orad_pkg::SYS_CTRL_IDX, 8'h0a);
      avs(1'b0, orad_pkg::SYS_CTRL_IDX, 8'h00);
      chk(rr, 32'h0000000a);
      // Prompt and slow far side
      for (int d = 0; d < 4; d += 3) begin
         @(posedge clk_i);
         mode_i <= 3'h2;
         delay <= 4'(d);
         cpu(1'b0, 1'b1, 24'h0fdf10, 16'h0000);
         chk(rd, 16'hdf10 ^ 16'h5a5a);
         cpu(1'b1, 1'b1, 24'h0fdf10, 16'hbeef + 16'(d));
         chk(last_wdata, 16'hbeef + 16'(d));
         chk(ext_word_o, 1'b1);
      end
      @(posedge clk_i);
      mode_i <= 3'h7;
      cpu(1'b1, 1'b1, 24'h0fdf10, 16'h0bad);
      cpu(1'b0, 1'b1, 24'h0fdf10, 16'h0000);
      chk(n, 3);
      chk(rd, 16'hffff);
      cpu(1'b0, 1'b0, 24'h0fff0f, 16'h0000);
      chk(rd, 16'hffff);
      // Status: mode 7, idle, blank access, not forwarded
      avs(1'b0, orad_pkg::STATUS_IDX, 8'h00);
      chk(rr, 32'h00000017);
      avs(1'b1, orad_pkg::SYS_CTRL_IDX, 8'h0b);
      cpu(1'b0, 1'b1, 24'h0fdf10, 16'h0000);
      chk(rd, 16'h1237);
      $display("test disable done");
   endtask

   task automatic t_reset;
      avs(1'b1, orad_pkg::SYS_CTRL_IDX, 8'h0a);
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      mode_i <= 3'h1;
      avs(1'b0, orad_pkg::SYS_CTRL_IDX, 8'h00);
      chk(rr, 32'h0000000b);
      cpu(1'b0, 1'b1, 24'h0fdf10, 16'h0000);
      chk(rd, 16'h1237);
      $display("test reset done");
   endtask

   // ----------------------------------------------------------------
   // Sequence and hang guard
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         stop_test();
      end
   end

   initial begin
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_modes();
      t_disable();
      t_reset();
      stop_test();
   end
endmodule
